// ==== core/urc_core.v ====
`timescale 1ns/1ps
`include "urc_consts.vh"
module urc_core (
  input wire REF_CLK_IN, // Processor clock, 25 MHz
  input wire RST_N_IN, // Async reset, active low
  input wire PORT_ON_IN, // Global enable
  input wire TRANSMIT_ON_IN, // Transmit enable
  input wire RECEIVE_ON_IN, // Receive enable
  input wire FIFO_ON_IN, // FIFO enable, depth one when low
  input wire [15:0] DIVISOR_IN, // Bit rate divisor, zero stops
  input wire [1:0] WORD_LEN_IN, // Data bit count code
  input wire TWO_STOP_IN, // Two stop bits
  input wire [2:0] PARITY_IN, // Parity mode
  input wire BREAK_IN, // Force line low
  input wire INFRARED_ENTER_IN, // Pulse, enter infrared mode
  input wire INFRARED_LP_REQ_IN, // Low power wanted with enter
  input wire INFRARED_LEAVE_IN, // Pulse, leave infrared mode
  input wire RX_DMA_ON_IN, // Receive DMA enable
  input wire TX_DMA_ON_IN, // Transmit DMA enable
  input wire STOP_RX_DMA_ON_ERROR_IN, // Error stops receive DMA
  input wire ERROR_CLEAR_IN, // Pulse, clear error flags
  input wire [7:0] TX_DATA_IN, // Character to send
  input wire TX_WRITE_IN, // Pulse, write character
  input wire RX_READ_IN, // Pulse, read character
  input wire SERIAL_RX_IN, // Serial line input
  output reg SERIAL_TX_OUT, // Serial line output
  output wire [10:0] RX_DATA_OUT, // Break, parity, framing, data
  output wire RX_AVAIL_OUT, // Receive FIFO not empty
  output wire TX_FULL_OUT, // Transmit FIFO full
  output wire BUSY_OUT, // Transmitter busy
  output reg [15:0] DIVISOR_OUT, // Divisor readback
  output reg [7:0] FORMAT_OUT, // Format readback
  output reg INFRARED_ON_OUT, // Infrared encoder enable bit
  output reg INFRARED_LOW_POWER_OUT, // Infrared low power bit
  output reg [3:0] ERROR_OUT, // Overrun, break, parity, framing
  output wire RX_DMA_REQ_OUT, // Receive DMA request
  output wire TX_DMA_REQ_OUT // Transmit DMA request
);
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_PAR = 3'h3;
  localparam ST_STOP = 3'h4;

  // Data bits for a length code
  function [3:0] bits_of;
    input [1:0] code;
    begin
      bits_of = 4'h5 + {2'h0, code};
    end
  endfunction

  // Parity bit for a mode and data word
  function par_of;
    input [2:0] mode;
    input [7:0] d;
    begin
      case (mode)
        `URC_PAR_EVEN: par_of = ^d;
        `URC_PAR_ODD: par_of = ~(^d);
        `URC_PAR_HIGH: par_of = 1'b1;
        default: par_of = 1'b0;
      endcase
    end
  endfunction

  // Mask data to the word length
  function [7:0] mask_of;
    input [1:0] code;
    input [7:0] d;
    begin
      mask_of = d & (8'hFF >> (3'h3 - {1'b0, code}));
    end
  endfunction

  wire en_tx = PORT_ON_IN & TRANSMIT_ON_IN;
  wire en_rx = PORT_ON_IN & RECEIVE_ON_IN;
  wire par_on = (PARITY_IN != `URC_PAR_ABSENT);
  reg [15:0] div_cnt;
  reg tick;
  reg rx_s1;
  reg rx_s2;
  reg port_on_d;
  wire flush_tx;
  wire [7:0] txf_data;
  wire txf_valid;
  wire txf_ready;
  reg tx_pop;
  reg [2:0] tx_st;
  reg [3:0] tx_tick;
  reg [3:0] tx_bit;
  reg [7:0] tx_sh;
  reg tx_stop2;
  reg [2:0] rx_st;
  reg [3:0] rx_tick;
  reg [3:0] rx_bit;
  reg [7:0] rx_sh;
  reg rx_par;
  reg [10:0] rx_word;
  reg rx_push;
  wire rxf_ready;
  reg dma_halt;
  wire rx_cap_full;
  wire tx_cap_full;
  wire rxf_valid;

  // Sixteen-times bit tick from the processor clock; zero divisor stops the tick and freezes any frame in progress
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (DIVISOR_IN == 16'h0000 || div_cnt + 16'h0001 >= DIVISOR_IN) begin
      div_cnt <= 16'h0000;
      tick <= (DIVISOR_IN != 16'h0000);
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // Readback of divisor and format
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      DIVISOR_OUT <= `URC_DIV_RESET;
      FORMAT_OUT <= 8'h00;
    end else begin
      DIVISOR_OUT <= DIVISOR_IN;
      FORMAT_OUT <= {2'h0, PARITY_IN, TWO_STOP_IN, WORD_LEN_IN};
    end
  end

  // Line input synchroniser
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= SERIAL_RX_IN;
      rx_s2 <= rx_s1;
    end
  end

  // Infrared control bits; a leave pulse wins over enter
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      INFRARED_ON_OUT <= 1'b0;
      INFRARED_LOW_POWER_OUT <= 1'b0;
    end else if (INFRARED_LEAVE_IN) begin
      INFRARED_ON_OUT <= 1'b0;
      INFRARED_LOW_POWER_OUT <= 1'b0;
    end else if (INFRARED_ENTER_IN) begin
      INFRARED_ON_OUT <= 1'b1;
      INFRARED_LOW_POWER_OUT <= INFRARED_LP_REQ_IN;
    end
  end

  // Falling global enable flushes queued transmit characters
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      port_on_d <= 1'b0;
    end else begin
      port_on_d <= PORT_ON_IN;
    end
  end
  assign flush_tx = port_on_d & ~PORT_ON_IN;

  // FIFO depth one when FIFOs are off
  assign tx_cap_full = ~FIFO_ON_IN & txf_valid;
  assign rx_cap_full = ~FIFO_ON_IN & rxf_valid;

  urc_fifo #(.WIDTH(`URC_TX_W), .DEPTH(`URC_FIFO_DEPTH), .AW(`URC_FIFO_AW)) u_txf (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RST_N_IN),
    .flush_in(flush_tx),
    .wr_data_in(TX_DATA_IN),
    .wr_valid_in(TX_WRITE_IN & ~tx_cap_full),
    .wr_ready_out(txf_ready),
    .rd_data_out(txf_data),
    .rd_valid_out(txf_valid),
    .rd_ready_in(tx_pop)
  );
  assign TX_FULL_OUT = ~txf_ready | tx_cap_full;
  assign TX_DMA_REQ_OUT = TX_DMA_ON_IN & en_tx & ~TX_FULL_OUT;

  // Transmitter; a started frame runs to its last stop bit even if disabled
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tx_st <= ST_IDLE;
      tx_tick <= 4'h0;
      tx_bit <= 4'h0;
      tx_sh <= 8'h00;
      tx_stop2 <= 1'b0;
      tx_pop <= 1'b0;
    end else begin
      tx_pop <= 1'b0;
      case (tx_st)
        ST_IDLE: begin
          if (en_tx && txf_valid && !tx_pop) begin
            tx_sh <= txf_data;
            tx_pop <= 1'b1;
            tx_tick <= 4'h0;
            tx_st <= ST_START;
          end
        end
        default: begin
          if (tick) begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == `URC_LAST_TICK) begin
              case (tx_st)
                ST_START: begin
                  tx_bit <= 4'h0;
                  tx_st <= ST_DATA;
                end
                ST_DATA: begin
                  tx_sh <= {1'b0, tx_sh[7:1]};
                  tx_bit <= tx_bit + 4'h1;
                  if (tx_bit + 4'h1 == bits_of(WORD_LEN_IN)) begin
                    tx_st <= par_on ? ST_PAR : ST_STOP;
                    tx_stop2 <= TWO_STOP_IN;
                  end
                end
                ST_PAR: begin
                  tx_st <= ST_STOP;
                end
                default: begin
                  if (tx_stop2) begin
                    tx_stop2 <= 1'b0;
                  end else begin
                    tx_st <= ST_IDLE;
                  end
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  // Parity held across the shift: computed from the popped character
  reg tx_par;
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tx_par <= 1'b0;
    end else if (tx_pop) begin
      tx_par <= par_of(PARITY_IN, mask_of(WORD_LEN_IN, txf_data));
    end
  end

  // Line level by state; break forces low
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      SERIAL_TX_OUT <= 1'b1;
    end else if (BREAK_IN) begin
      SERIAL_TX_OUT <= 1'b0;
    end else begin
      case (tx_st)
        ST_START: SERIAL_TX_OUT <= 1'b0;
        ST_DATA: SERIAL_TX_OUT <= tx_sh[0];
        ST_PAR: SERIAL_TX_OUT <= tx_par;
        default: SERIAL_TX_OUT <= 1'b1;
      endcase
    end
  end
  // Idle state is entered only after the last stop bit, when the line already stands high
  assign BUSY_OUT = txf_valid | (tx_st != ST_IDLE) | tx_pop;

  // Receiver, mid-bit sampling on the sixteen-times tick
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rx_st <= ST_IDLE;
      rx_tick <= 4'h0;
      rx_bit <= 4'h0;
      rx_sh <= 8'h00;
      rx_par <= 1'b0;
      rx_word <= 11'h000;
      rx_push <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      if (!en_rx) begin
        rx_st <= ST_IDLE;
      end else if (tick) begin
        rx_tick <= rx_tick + 4'h1;
        case (rx_st)
          ST_IDLE: begin
            rx_tick <= 4'h0;
            if (!rx_s2) begin
              rx_st <= ST_START;
            end
          end
          ST_START: begin
            if (rx_tick == `URC_MID_SAMPLE) begin
              rx_tick <= 4'h0;
              rx_bit <= 4'h0;
              rx_sh <= 8'h00;
              rx_st <= rx_s2 ? ST_IDLE : ST_DATA; // Glitch rejected
            end
          end
          ST_DATA: begin
            if (rx_tick == `URC_LAST_TICK) begin
              rx_sh[rx_bit[2:0]] <= rx_s2;
              rx_bit <= rx_bit + 4'h1;
              if (rx_bit + 4'h1 == bits_of(WORD_LEN_IN)) begin
                rx_st <= par_on ? ST_PAR : ST_STOP;
              end
            end
          end
          ST_PAR: begin
            if (rx_tick == `URC_LAST_TICK) begin
              rx_par <= rx_s2;
              rx_st <= ST_STOP;
            end
          end
          default: begin
            // One stop bit checked; a second is accepted as idle line
            if (rx_tick == `URC_LAST_TICK) begin
              rx_word[7:0] <= rx_sh;
              rx_word[`URC_RX_FE_BIT] <= ~rx_s2;
              rx_word[`URC_RX_PE_BIT] <= par_on & (rx_par != par_of(PARITY_IN, rx_sh));
              rx_word[`URC_RX_BE_BIT] <= ~rx_s2 & (rx_sh == 8'h00);
              rx_push <= 1'b1;
              rx_st <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  urc_fifo #(.WIDTH(`URC_RX_W), .DEPTH(`URC_FIFO_DEPTH), .AW(`URC_FIFO_AW)) u_rxf (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RST_N_IN),
    .flush_in(1'b0),
    .wr_data_in(rx_word),
    .wr_valid_in(rx_push & ~rx_cap_full),
    .wr_ready_out(rxf_ready),
    .rd_data_out(RX_DATA_OUT),
    .rd_valid_out(rxf_valid),
    .rd_ready_in(RX_READ_IN)
  );
  assign RX_AVAIL_OUT = rxf_valid;

  // Sticky errors and DMA halt; a new error wins over clear
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ERROR_OUT <= 4'h0;
      dma_halt <= 1'b0;
    end else begin
      ERROR_OUT <= (ERROR_CLEAR_IN ? 4'h0 : ERROR_OUT) |
        (rx_push ? {~rxf_ready | rx_cap_full, rx_word[`URC_RX_BE_BIT],
        rx_word[`URC_RX_PE_BIT], rx_word[`URC_RX_FE_BIT]} : 4'h0);
      if (rx_push && STOP_RX_DMA_ON_ERROR_IN &&
          (rx_word[10:8] != 3'h0 || !rxf_ready || rx_cap_full)) begin
        dma_halt <= 1'b1;
      end else if (ERROR_CLEAR_IN || !RX_DMA_ON_IN) begin
        dma_halt <= 1'b0;
      end
    end
  end
  assign RX_DMA_REQ_OUT = RX_DMA_ON_IN & rxf_valid & ~dma_halt;
endmodule

// ==== inc/urc_consts.vh ====
`ifndef URC_CONSTS_VH
`define URC_CONSTS_VH
// Word length field codes
`define URC_WLEN_FIVE 2'h0
`define URC_WLEN_SIX 2'h1
`define URC_WLEN_SEVEN 2'h2
`define URC_WLEN_EIGHT 2'h3
// Parity field codes
`define URC_PAR_ABSENT 3'h0
`define URC_PAR_EVEN 3'h1
`define URC_PAR_ODD 3'h2
`define URC_PAR_HIGH 3'h3
`define URC_PAR_LOW 3'h4
// Oversampling and FIFO shape
`define URC_OVERSAMPLE 5'h10
`define URC_MID_SAMPLE 4'h7
`define URC_LAST_TICK 4'hF
`define URC_FIFO_DEPTH 16
`define URC_FIFO_AW 4
`define URC_TX_W 8
`define URC_RX_W 11
// Status bits of a received word, above the data byte
`define URC_RX_FE_BIT 8
`define URC_RX_PE_BIT 9
`define URC_RX_BE_BIT 10
// Divisor reset value
`define URC_DIV_RESET 16'h0001
`endif

// ==== core/urc_fifo.v ====
`timescale 1ns/1ps
module urc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_in, // Clock
  input wire rst_n_in, // Async reset, active low
  input wire flush_in, // Discard all entries
  input wire [WIDTH-1:0] wr_data_in, // Write data
  input wire wr_valid_in, // Write request
  output wire wr_ready_out, // Space available
  output wire [WIDTH-1:0] rd_data_out, // Oldest entry
  output wire rd_valid_out, // Entry available
  input wire rd_ready_in // Pop oldest entry
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;

  // Honest flags from one occupancy count
  assign wr_ready_out = (count != DEPTH[AW:0]);
  assign rd_valid_out = (count != {(AW+1){1'b0}});
  assign do_wr = wr_valid_in & wr_ready_out & ~flush_in;
  assign do_rd = rd_ready_in & rd_valid_out & ~flush_in;
  assign rd_data_out = mem[rd_ptr];

  // Storage written without reset to keep it small
  always @(posedge clk_in) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end

  // Pointers and occupancy
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (flush_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd & ~do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ==== bench/urc_line_model.sv ====
`timescale 1ns/1ps
// Remote serial device: decodes the device's line and sends frames to it
module urc_line_model (
  input wire logic clk_in, // Bench clock
  input wire logic tx_line_in, // Device transmit line
  output logic rx_line_out, // Device receive line
  input wire logic [15:0] div_in, // Rate divisor
  input wire logic [3:0] nbits_in // Frame length in bits
);
  logic [11:0] got = 12'hFFF;
  int n_frames = 0;
  // Idle line sits high, as a pulled-up serial line does
  initial rx_line_out = 1'b1;
  // Mid-bit sampling from the start edge; no wait after the last stop,
  // so a start bit that follows at once is not missed
  always begin
    @(negedge tx_line_in);
    repeat (8 * div_in) @(posedge clk_in);
    got = 12'hFFF;
    for (int k = 0; k < nbits_in; k++) begin
      if (k > 0)
        repeat (16 * div_in) @(posedge clk_in);
      got[k] = tx_line_in;
    end
    n_frames++;
  end
  // Send line bits, start bit first, then return to idle
  task automatic send(input logic [11:0] bits, input logic [3:0] n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_in);
      rx_line_out <= bits[k];
      repeat (16 * div_in - 1) @(posedge clk_in);
    end
    @(posedge clk_in);
    rx_line_out <= 1'b1;
  endtask
endmodule

// ==== bench/urc_core_sva.sv ====
`timescale 1ns/1ps
// Port checker of the serial core
module urc_core_sva (
  input wire logic REF_CLK_IN, // Clock
  input wire logic RST_N_IN, // Reset
  input wire logic PORT_ON_IN, // Global enable
  input wire logic TRANSMIT_ON_IN, // Tx enable
  input wire logic [15:0] DIVISOR_IN, // Divisor
  input wire logic [1:0] WORD_LEN_IN, // Word length
  input wire logic TWO_STOP_IN, // Stop bits
  input wire logic [2:0] PARITY_IN, // Parity
  input wire logic BREAK_IN, // Break
  input wire logic INFRARED_ENTER_IN, // Enter
  input wire logic INFRARED_LP_REQ_IN, // Low power
  input wire logic INFRARED_LEAVE_IN, // Leave
  input wire logic RX_DMA_ON_IN, // Rx DMA
  input wire logic TX_DMA_ON_IN, // Tx DMA
  input wire logic STOP_RX_DMA_ON_ERROR_IN, // Error stop
  input wire logic ERROR_CLEAR_IN, // Clear
  input wire logic TX_WRITE_IN, // Write
  input wire logic SERIAL_TX_OUT, // Line
  input wire logic RX_AVAIL_OUT, // Rx avail
  input wire logic TX_FULL_OUT, // Tx full
  input wire logic BUSY_OUT, // Busy
  input wire logic [15:0] DIVISOR_OUT, // Readback
  input wire logic [7:0] FORMAT_OUT, // Readback
  input wire logic INFRARED_ON_OUT, // Ir enable
  input wire logic INFRARED_LOW_POWER_OUT, // Ir low power
  input wire logic [3:0] ERROR_OUT, // Errors
  input wire logic RX_DMA_REQ_OUT, // Rx request
  input wire logic TX_DMA_REQ_OUT // Tx request
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Frame bound covers divisors up to 3 with the longest format
  // Line is registered, so it lags a released break by one cycle
  property p_idle_line; !BUSY_OUT && !BREAK_IN && !$past(BREAK_IN) |-> SERIAL_TX_OUT; endproperty
  property p_write_busy; TX_WRITE_IN && !TX_FULL_OUT && PORT_ON_IN && TRANSMIT_ON_IN |=> BUSY_OUT; endproperty
  property p_tx_dma; TX_DMA_REQ_OUT |-> TX_DMA_ON_IN && !TX_FULL_OUT; endproperty
  property p_rx_dma; RX_DMA_REQ_OUT |-> RX_DMA_ON_IN && RX_AVAIL_OUT; endproperty
  property p_err_halt;
    $rose(|ERROR_OUT) && STOP_RX_DMA_ON_ERROR_IN && !ERROR_CLEAR_IN |-> ##[0:1] !RX_DMA_REQ_OUT;
  endproperty
  property p_ir_leave; INFRARED_LEAVE_IN |=> !INFRARED_ON_OUT && !INFRARED_LOW_POWER_OUT; endproperty
  property p_ir_enter;
    INFRARED_ENTER_IN && !INFRARED_LEAVE_IN |=> INFRARED_ON_OUT && (INFRARED_LOW_POWER_OUT || !$past(INFRARED_LP_REQ_IN));
  endproperty
  property p_readback;
    $past(RST_N_IN) |-> DIVISOR_OUT == $past(DIVISOR_IN)
      && FORMAT_OUT == {2'h0, $past(PARITY_IN), $past(TWO_STOP_IN), $past(WORD_LEN_IN)};
  endproperty
  property p_disable_done; $fell(PORT_ON_IN) |-> ##[0:700] !BUSY_OUT; endproperty
  property p_flush; $fell(PORT_ON_IN) |-> ##[1:2] !TX_FULL_OUT; endproperty
  a_idle_line: assert property (p_idle_line) else $error("line low while idle");
  a_write_busy: assert property (p_write_busy) else $error("no busy after write");
  a_tx_dma: assert property (p_tx_dma) else $error("bad tx dma request");
  a_rx_dma: assert property (p_rx_dma) else $error("bad rx dma request");
  a_err_halt: assert property (p_err_halt) else $error("rx dma not halted");
  a_ir_leave: assert property (p_ir_leave) else $error("infrared bits kept");
  a_ir_enter: assert property (p_ir_enter) else $error("infrared bits not set");
  a_readback: assert property (p_readback) else $error("readback wrong");
  a_disable_done: assert property (p_disable_done) else $error("frame never ended");
  a_flush: assert property (p_flush) else $error("tx fifo not flushed");
  c_full: cover property (TX_FULL_OUT);
  c_err: cover property (|ERROR_OUT);
  c_both: cover property (BUSY_OUT && RX_AVAIL_OUT);
endmodule
bind urc_core urc_core_sva u_sva (.*);

// ==== bench/uart_core_control_bench.sv ====
`timescale 1ns/1ps
module uart_core_control_bench;
  logic REF_CLK_IN, RST_N_IN, PORT_ON_IN, TRANSMIT_ON_IN, RECEIVE_ON_IN, FIFO_ON_IN;
  logic TWO_STOP_IN, BREAK_IN, INFRARED_ENTER_IN, INFRARED_LP_REQ_IN, INFRARED_LEAVE_IN;
  logic RX_DMA_ON_IN, TX_DMA_ON_IN, STOP_RX_DMA_ON_ERROR_IN, ERROR_CLEAR_IN;
  logic TX_WRITE_IN, RX_READ_IN, SERIAL_RX_IN, SERIAL_TX_OUT, RX_AVAIL_OUT, TX_FULL_OUT, BUSY_OUT;
  logic INFRARED_ON_OUT, INFRARED_LOW_POWER_OUT, RX_DMA_REQ_OUT, TX_DMA_REQ_OUT;
  logic [15:0] DIVISOR_IN, DIVISOR_OUT;
  logic [1:0] WORD_LEN_IN;
  logic [2:0] PARITY_IN;
  logic [7:0] TX_DATA_IN, FORMAT_OUT;
  logic [10:0] RX_DATA_OUT;
  logic [3:0] ERROR_OUT, nbits;
  logic [31:0] seed = 32'h390EFB28;
  logic [7:0] d [3];
  int error_cnt = 0, n_tests = 0, i, j, n0;
  urc_core DUT (.*);
  urc_line_model line (.clk_in(REF_CLK_IN), .tx_line_in(SERIAL_TX_OUT), .rx_line_out(SERIAL_RX_IN),
    .div_in(DIVISOR_IN), .nbits_in(nbits));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Line bits of one frame, start first; stops and spare bits high
  function automatic logic [11:0] frame(input logic [7:0] dt, input logic [1:0] w, input logic [2:0] p);
    logic [11:0] r;
    logic [7:0] m;
    r = 12'hFFF;
    m = 8'hFF >> (2'h3 - w);
    r[0] = 1'b0;
    for (int k = 0; k < 5 + w; k++)
      r[k + 1] = dt[k];
    if (p != 3'h0)
      r[6 + w] = (p == 3'h1) ? ^(dt & m) : (p == 3'h2) ? ~^(dt & m) : (p == 3'h3);
    return r;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Bounded waits, so a stuck design ends in a mismatch, not a hang
  task automatic wait_frames(input int k);
    for (int t = 0; t < 4000 && line.n_frames < k; t++)
      @(posedge REF_CLK_IN);
    #1;
  endtask
  task automatic wait_idle;
    for (int t = 0; t < 1000 && BUSY_OUT; t++)
      @(posedge REF_CLK_IN);
    #1;
  endtask
  task automatic pulse_read;
    @(posedge REF_CLK_IN);
    RX_READ_IN <= 1'b1;
    @(posedge REF_CLK_IN);
    RX_READ_IN <= 1'b0;
    #1;
  endtask
  // Clock at 25 MHz
  initial begin
    REF_CLK_IN = 1'b0;
    forever #20 REF_CLK_IN = ~REF_CLK_IN;
  end
  // Watchdog well above the expected run length
  initial begin
    repeat (90000) @(posedge REF_CLK_IN);
    error_cnt++;
    end_sim;
  end
  initial begin
    {RST_N_IN, BREAK_IN, INFRARED_ENTER_IN, INFRARED_LEAVE_IN, ERROR_CLEAR_IN, TX_WRITE_IN, RX_READ_IN} = 7'h00;
    {PORT_ON_IN, TRANSMIT_ON_IN, RECEIVE_ON_IN, FIFO_ON_IN, RX_DMA_ON_IN, TX_DMA_ON_IN} = 6'h3F;
    {STOP_RX_DMA_ON_ERROR_IN, INFRARED_LP_REQ_IN, TWO_STOP_IN, WORD_LEN_IN, PARITY_IN} = 8'h18;
    {TX_DATA_IN, DIVISOR_IN, nbits} = 28'h000001A;
    @(posedge REF_CLK_IN);
    #1 chk({SERIAL_TX_OUT, BUSY_OUT, RX_AVAIL_OUT, FORMAT_OUT}, 16'h0400);
    chk(DIVISOR_OUT, 16'h0001);
    @(posedge REF_CLK_IN);
    RST_N_IN <= 1'b1;
    // Every word length and parity code, random data and stop count
    for (i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      @(posedge REF_CLK_IN);
      WORD_LEN_IN <= i[1:0];
      PARITY_IN <= 3'(i % 5);
      TWO_STOP_IN <= seed[5];
      DIVISOR_IN <= {15'h0000, seed[6]} + 16'h0001;
      @(posedge REF_CLK_IN);
      #1 chk(FORMAT_OUT, {2'h0, PARITY_IN, TWO_STOP_IN, WORD_LEN_IN});
      chk(DIVISOR_OUT, DIVISOR_IN);
      nbits = 4'h7 + WORD_LEN_IN + (PARITY_IN != 3'h0) + TWO_STOP_IN;
      n0 = line.n_frames;
      d[0] = seed[15:8];
      d[1] = seed[23:16];
      @(posedge REF_CLK_IN);
      TX_DATA_IN <= d[0];
      TX_WRITE_IN <= 1'b1;
      @(posedge REF_CLK_IN);
      TX_DATA_IN <= d[1];
      @(posedge REF_CLK_IN);
      TX_WRITE_IN <= 1'b0;
      #1 chk(BUSY_OUT, 1'b1);
      for (j = 0; j < 2; j++) begin
        wait_frames(n0 + j + 1);
        chk(line.got, frame(d[j], WORD_LEN_IN, PARITY_IN));
      end
      wait_idle();
      chk(BUSY_OUT, 1'b0);
      // Three frames in before any read
      for (j = 0; j < 3; j++) begin
        seed = lfsr(seed);
        d[j] = seed[7:0];
        line.send(frame(d[j], WORD_LEN_IN, PARITY_IN), nbits);
      end
      repeat (4) @(posedge REF_CLK_IN);
      #1 chk(RX_DMA_REQ_OUT, 1'b1);
      for (j = 0; j < 3; j++) begin
        chk(RX_AVAIL_OUT, 1'b1);
        chk(RX_DATA_OUT, d[j] & (8'hFF >> (2'h3 - WORD_LEN_IN)));
        pulse_read();
      end
      chk(RX_AVAIL_OUT, 1'b0);
    end
    // Parity error with the error stop on
    @(posedge REF_CLK_IN);
    {STOP_RX_DMA_ON_ERROR_IN, PARITY_IN, WORD_LEN_IN, TWO_STOP_IN, DIVISOR_IN} <= {1'b1, 3'h1, 2'h3, 1'b0, 16'h0001};
    @(posedge REF_CLK_IN);
    #1 nbits = 4'hB;
    line.send(frame(8'hA5, 2'h3, 3'h1) ^ 12'h200, nbits);
    repeat (4) @(posedge REF_CLK_IN);
    #1 chk(RX_DATA_OUT, 11'h2A5);
    chk({ERROR_OUT, RX_DMA_REQ_OUT}, 5'h04);
    // Fill the transmit FIFO past full at a slow rate, then disable
    @(posedge REF_CLK_IN);
    {DIVISOR_IN, ERROR_CLEAR_IN, RX_READ_IN, TX_WRITE_IN} <= {16'h0003, 3'h7};
    n0 = line.n_frames;
    for (j = 0; j < 18; j++) begin
      TX_DATA_IN <= j[7:0];
      @(posedge REF_CLK_IN);
      {ERROR_CLEAR_IN, RX_READ_IN} <= 2'h0;
    end
    TX_WRITE_IN <= 1'b0;
    #1 chk({TX_FULL_OUT, TX_DMA_REQ_OUT}, 2'h2);
    @(posedge REF_CLK_IN);
    {PORT_ON_IN, TRANSMIT_ON_IN, RECEIVE_ON_IN} <= 3'h0;
    repeat (2) @(posedge REF_CLK_IN);
    #1 chk(TX_FULL_OUT, 1'b0);
    wait_idle();
    chk(line.n_frames, n0 + 1);
    chk(line.got, frame(8'h00, 2'h3, 3'h1));
    @(posedge REF_CLK_IN);
    {PORT_ON_IN, TRANSMIT_ON_IN, RECEIVE_ON_IN} <= 3'h7;
    repeat (300) @(posedge REF_CLK_IN);
    #1 chk({line.n_frames[7:0], BUSY_OUT}, {8'(n0 + 1), 1'b0});
    // Break held over two full frames; far end sends one frame of low line
    @(posedge REF_CLK_IN);
    BREAK_IN <= 1'b1;
    line.send(12'h000, nbits);
    repeat (600) @(posedge REF_CLK_IN);
    #1 chk({SERIAL_TX_OUT, ERROR_OUT[2], ERROR_OUT[0]}, 3'h3);
    @(posedge REF_CLK_IN);
    BREAK_IN <= 1'b0;
    // FIFOs off with the transmitter held: one character fills the path
    @(posedge REF_CLK_IN);
    {FIFO_ON_IN, TRANSMIT_ON_IN, TX_WRITE_IN} <= 3'h1;
    @(posedge REF_CLK_IN);
    TX_WRITE_IN <= 1'b0;
    #1 chk({TX_FULL_OUT, BUSY_OUT}, 2'h3);
    // Infrared mode in and out
    @(posedge REF_CLK_IN);
    {INFRARED_ENTER_IN, INFRARED_LP_REQ_IN} <= 2'h3;
    @(posedge REF_CLK_IN);
    INFRARED_ENTER_IN <= 1'b0;
    #1 chk({INFRARED_ON_OUT, INFRARED_LOW_POWER_OUT}, 2'h3);
    @(posedge REF_CLK_IN);
    INFRARED_LEAVE_IN <= 1'b1;
    @(posedge REF_CLK_IN);
    INFRARED_LEAVE_IN <= 1'b0;
    #1 chk({INFRARED_ON_OUT, INFRARED_LOW_POWER_OUT}, 2'h0);
    end_sim;
  end
endmodule
